//--- src/mpd_defines.svh
// offsets, field positions, reset values and timing counts of the port register bank
// assumes word-index addressing: byte address is four times the index
`ifndef MPD_DEFINES_SVH
`define MPD_DEFINES_SVH
`define MPD_OFS_SA_LOW   5'h00
`define MPD_OFS_SA_HIGH  5'h01
`define MPD_OFS_DUPLEX   5'h02
`define MPD_OFS_PTYPE    5'h03
`define MPD_OFS_STATUS   5'h1f
`define MPD_BASE_MAX     3'h5
`define MPD_RST_SA_LOW   32'h0000_0000
`define MPD_RST_SA_HIGH  16'h0000
`define MPD_RST_DUPLEX   1'h1
`define MPD_RST_PTYPE    16'h8808
`define MPD_SA_LOW_W     32
`define MPD_SA_HIGH_W    16
`define MPD_PTYPE_W      16
`define MPD_DUPLEX_BIT   0
`define MPD_ST_FDX_BIT   0
`define MPD_ST_TXBUSY_BIT 1
`define MPD_ST_RXHIT_BIT 2
`define MPD_BUS_WAIT     1
`endif

//--- src/mpd_pkg.sv
// types shared by the port register bank and its pause frame context
// assumes mpd_defines.svh is on the include path
package mpd_pkg;
  typedef enum logic [1:0] {mpd_media_rgmii, mpd_media_gmii, mpd_media_fiber} mpd_media_e;
  typedef enum logic [1:0] {mpd_spd_10, mpd_spd_100, mpd_spd_1000} mpd_speed_e;
  typedef enum logic {mpd_tx_idle, mpd_tx_frame} mpd_tx_e;

  typedef struct packed {
    mpd_media_e media;
    mpd_speed_e speed;
  } mpd_link_s;

  typedef struct packed {
    logic [47:0] station;
    logic        duplex;
    logic [15:0] ptype;
  } mpd_cfg_s;

  typedef struct packed {
    logic        valid;
    logic        unicast;
    logic [47:0] dst;
  } mpd_rx_req_s;

  typedef struct packed {
    logic [47:0] src;
    logic [15:0] ptype;
  } mpd_tx_hdr_s;

  typedef struct packed {
    logic        captured;
    logic        base_ok;
    logic [2:0]  base;
    mpd_cfg_s    cfg;
    logic        waitreq;
    logic [31:0] rdata;
    logic        fdx;
  } mpd_bank_s;

  typedef struct packed {
    mpd_tx_e     phase;
    logic        busy;
    mpd_tx_hdr_s hdr;
    logic        hit;
    logic        seen;
  } mpd_ctx_s;
endpackage : mpd_pkg

//--- src/mpd_pause_ctx.sv
// pause frame header snapshot for transmit and station match for receive
// assumes the pause datapath runs on mclk and frames start with a one-cycle pulse
`timescale 1ns/1ns
`include "mpd_defines.svh"
module mpd_pause_ctx
  import mpd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire mpd_cfg_s    cfg,
  input  wire logic        tx_pause_start,
  input  wire logic        tx_pause_end,
  input  wire mpd_rx_req_s rx_req,
  output mpd_tx_hdr_s      tx_hdr,
  output logic             tx_busy,
  output logic             rx_pause_hit,
  output logic             rx_pause_seen
);
  mpd_ctx_s st;
  mpd_ctx_s next_st;
  logic     match;

  always_comb begin
    next_st = st;
    match = rx_req.valid && rx_req.unicast && (rx_req.dst == cfg.station);
    unique case (st.phase)
      mpd_tx_idle: begin
        if (tx_pause_start) begin
          next_st.phase = mpd_tx_frame;
        end
      end
      mpd_tx_frame: begin
        if (tx_pause_end && !tx_pause_start) begin
          next_st.phase = mpd_tx_idle;
        end
      end
    endcase
    if (tx_pause_start) begin
      next_st.hdr.src   = cfg.station;
      next_st.hdr.ptype = cfg.ptype;
    end
    next_st.busy = (next_st.phase == mpd_tx_frame);
    next_st.hit  = match;
    if (rx_req.valid) begin
      next_st.seen = match;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st.phase     <= mpd_tx_idle;
      st.busy      <= 1'b0;
      st.hdr.src   <= {`MPD_RST_SA_HIGH, `MPD_RST_SA_LOW};
      st.hdr.ptype <= `MPD_RST_PTYPE;
      st.hit       <= 1'b0;
      st.seen      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign tx_hdr        = st.hdr;
  assign tx_busy       = st.busy;
  assign rx_pause_hit  = st.hit;
  assign rx_pause_seen = st.seen;

  property p_tx_load;
    @(posedge mclk) disable iff (!nrst)
    tx_pause_start |=> (tx_hdr.src == $past(cfg.station)) && tx_busy;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx header not loaded");

  property p_tx_hold;
    @(posedge mclk) disable iff (!nrst)
    (tx_busy && !tx_pause_start) |=> $stable(tx_hdr);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx header moved mid frame");

  property p_rx_match;
    @(posedge mclk) disable iff (!nrst)
    (rx_req.valid && rx_req.unicast && rx_req.dst == cfg.station) |=> rx_pause_hit;
  endproperty
  a_rx_match: assert property (p_rx_match) else $error("unicast pause not matched");

  property p_rx_quiet;
    @(posedge mclk) disable iff (!nrst)
    (!rx_req.valid || rx_req.dst != cfg.station) |=> !rx_pause_hit;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("false pause match");

  c_tx_frame: cover property (@(posedge mclk) disable iff (!nrst)
    tx_pause_start ##1 tx_busy [*3] ##1 !tx_busy);
endmodule : mpd_pause_ctx

//--- src/mpd_port_regs.sv
// per-port station address, duplex choice and pause type registers on avalon-mm
// assumes pause datapath and link mode signals run on mclk
//
// What this block does
// - registers sit at port base index plus offset; base 0x0 to 0x5 accepted
// - every register is 32 bits; unused bits read zero and ignore writes
// - station address low holds bits 31-0, high bits 15:0 hold 47:32
// - transmitted pause frames carry the station address as source address
// - received unicast pause frames are matched against the station address
// - duplex bit 0 picks half (0) or full (1) on rgmii 10/100 only
// - half duplex only on copper rgmii 10/100; gigabit always full duplex
// - pause type bits 15:0 fill the frame type field, reset 0x8808
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`include "mpd_defines.svh"
module mpd_port_regs
  import mpd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic [2:0]        port_index,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire mpd_link_s         link,
  input  wire logic              tx_pause_start,
  input  wire logic              tx_pause_end,
  input  wire mpd_rx_req_s       rx_req,
  output mpd_tx_hdr_s            tx_hdr,
  output logic                   tx_busy,
  output logic                   rx_pause_hit,
  output logic                   full_duplex
);
  mpd_bank_s st;
  mpd_bank_s next_st;
  logic      req;
  logic      rx_seen;
  logic      wr_go;

  // address of a register at base plus offset
  function automatic logic mpd_sel(
    input logic [ADDR_W-1:0] addr,
    input logic              ok,
    input logic [2:0]        base,
    input logic [4:0]        ofs
  );
    mpd_sel = ok && (addr == (ADDR_W'(base) + ADDR_W'(ofs)));
  endfunction : mpd_sel

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] mpd_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] w;
    w = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        w[8*i +: 8] = wd[8*i +: 8];
      end
    end
    mpd_merge = w;
  endfunction : mpd_merge

  // duplex seen by the mac for the current link
  function automatic logic mpd_eff_fdx(
    input mpd_link_s l,
    input logic      dup
  );
    logic slow_copper;
    slow_copper = (l.media == mpd_media_rgmii) && (l.speed != mpd_spd_1000);
    mpd_eff_fdx = slow_copper ? dup : 1'h1;
  endfunction : mpd_eff_fdx

  // read mux, unused bits zero
  function automatic logic [31:0] mpd_read(
    input logic [ADDR_W-1:0] addr,
    input mpd_bank_s         b,
    input logic              busy,
    input logic              seen
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    if (mpd_sel(addr, b.base_ok, b.base, `MPD_OFS_SA_LOW)) begin
      r = b.cfg.station[31:0];
    end
    if (mpd_sel(addr, b.base_ok, b.base, `MPD_OFS_SA_HIGH)) begin
      r[`MPD_SA_HIGH_W-1:0] = b.cfg.station[47:32];
    end
    if (mpd_sel(addr, b.base_ok, b.base, `MPD_OFS_DUPLEX)) begin
      r[`MPD_DUPLEX_BIT] = b.cfg.duplex;
    end
    if (mpd_sel(addr, b.base_ok, b.base, `MPD_OFS_PTYPE)) begin
      r[`MPD_PTYPE_W-1:0] = b.cfg.ptype;
    end
    if (mpd_sel(addr, b.base_ok, b.base, `MPD_OFS_STATUS)) begin
      r[`MPD_ST_FDX_BIT]    = b.fdx;
      r[`MPD_ST_TXBUSY_BIT] = busy;
      r[`MPD_ST_RXHIT_BIT]  = seen;
    end
    mpd_read = r;
  endfunction : mpd_read

  always_comb begin
    logic [31:0] m;
    m       = 32'h0000_0000;
    next_st = st;
    req     = avs_read || avs_write;
    wr_go   = avs_write && !st.waitreq;
    // base index caught once after reset release
    if (!st.captured) begin
      next_st.captured = 1'h1;
      next_st.base     = port_index;
      next_st.base_ok  = (port_index <= `MPD_BASE_MAX);
    end
    // one wait state, then the transfer completes
    if (st.captured && req && st.waitreq) begin
      next_st.waitreq = 1'h0;
      next_st.rdata   = avs_read ? mpd_read(avs_address, st, tx_busy, rx_seen)
                                 : 32'h0000_0000;
    end else if (!st.waitreq) begin
      next_st.waitreq = 1'h1;
    end
    if (wr_go) begin
      if (mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_SA_LOW)) begin
        next_st.cfg.station[31:0] =
          mpd_merge(st.cfg.station[31:0], avs_writedata, avs_byteenable);
      end
      if (mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_SA_HIGH)) begin
        m = mpd_merge({16'h0000, st.cfg.station[47:32]}, avs_writedata, avs_byteenable);
        next_st.cfg.station[47:32] = m[`MPD_SA_HIGH_W-1:0];
      end
      if (mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_DUPLEX)) begin
        if (avs_byteenable[0]) begin
          next_st.cfg.duplex = avs_writedata[`MPD_DUPLEX_BIT];
        end
      end
      if (mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_PTYPE)) begin
        m = mpd_merge({16'h0000, st.cfg.ptype}, avs_writedata, avs_byteenable);
        next_st.cfg.ptype = m[`MPD_PTYPE_W-1:0];
      end
    end
    next_st.fdx = mpd_eff_fdx(link, st.cfg.duplex);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st.captured    <= 1'h0;
      st.base_ok     <= 1'h0;
      st.base        <= 3'h0;
      st.cfg.station <= {`MPD_RST_SA_HIGH, `MPD_RST_SA_LOW};
      st.cfg.duplex  <= `MPD_RST_DUPLEX;
      st.cfg.ptype   <= `MPD_RST_PTYPE;
      st.waitreq     <= 1'h1;
      st.rdata       <= 32'h0000_0000;
      st.fdx         <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign full_duplex     = st.fdx;

  mpd_pause_ctx u_ctx (
    .mclk           (mclk),
    .nrst           (nrst),
    .cfg            (st.cfg),
    .tx_pause_start (tx_pause_start),
    .tx_pause_end   (tx_pause_end),
    .rx_req         (rx_req),
    .tx_hdr         (tx_hdr),
    .tx_busy        (tx_busy),
    .rx_pause_hit   (rx_pause_hit),
    .rx_pause_seen  (rx_seen)
  );

  // helper flags for the checks below
  logic last_rd_dup;
  logic last_rd_high;
  logic last_rd_any;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      last_rd_dup  <= 1'h0;
      last_rd_high <= 1'h0;
      last_rd_any  <= 1'h0;
    end else begin
      last_rd_any  <= st.captured && avs_read && st.waitreq;
      last_rd_dup  <= st.captured && avs_read && st.waitreq &&
                      mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_DUPLEX);
      last_rd_high <= st.captured && avs_read && st.waitreq &&
                      mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_SA_HIGH);
    end
  end

  property p_bus_wait;
    @(posedge mclk) disable iff (!nrst)
    (st.captured && req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("waitrequest timing wrong");

  property p_base_bad;
    @(posedge mclk) disable iff (!nrst)
    (last_rd_any && !st.base_ok) |-> (avs_readdata == 32'h0000_0000);
  endproperty
  a_base_bad: assert property (p_base_bad) else $error("bad base decoded");

  property p_dup_zero;
    @(posedge mclk) disable iff (!nrst)
    last_rd_dup |-> (avs_readdata[31:1] == 31'h0000_0000) &&
                    (avs_readdata[0] == st.cfg.duplex);
  endproperty
  a_dup_zero: assert property (p_dup_zero) else $error("duplex readback wrong");

  property p_high_zero;
    @(posedge mclk) disable iff (!nrst)
    last_rd_high |-> (avs_readdata[31:16] == 16'h0000) &&
                     (avs_readdata[15:0] == st.cfg.station[47:32]);
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("high address readback wrong");

  property p_low_write;
    @(posedge mclk) disable iff (!nrst)
    (wr_go && avs_byteenable == 4'hf &&
     mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_SA_LOW))
    |=> (st.cfg.station[31:0] == $past(avs_writedata));
  endproperty
  a_low_write: assert property (p_low_write) else $error("low address not written");

  property p_ptype_write;
    @(posedge mclk) disable iff (!nrst)
    (wr_go && avs_byteenable == 4'hf &&
     mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_PTYPE))
    |=> (st.cfg.ptype == $past(avs_writedata[15:0]));
  endproperty
  a_ptype_write: assert property (p_ptype_write) else $error("pause type not written");

  property p_gig_full;
    @(posedge mclk) disable iff (!nrst)
    (link.media != mpd_media_rgmii || link.speed == mpd_spd_1000) |=> full_duplex;
  endproperty
  a_gig_full: assert property (p_gig_full) else $error("half duplex on gigabit");

  property p_dup_sel;
    @(posedge mclk) disable iff (!nrst)
    (link.media == mpd_media_rgmii && link.speed != mpd_spd_1000)
    |=> (full_duplex == $past(st.cfg.duplex));
  endproperty
  a_dup_sel: assert property (p_dup_sel) else $error("duplex select ignored");

  property p_tx_type;
    @(posedge mclk) disable iff (!nrst)
    tx_pause_start |=> (tx_hdr.ptype == $past(st.cfg.ptype));
  endproperty
  a_tx_type: assert property (p_tx_type) else $error("frame type not from register");

  c_write_low: cover property (@(posedge mclk) disable iff (!nrst)
    wr_go && mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_SA_LOW));
  c_half_duplex: cover property (@(posedge mclk) disable iff (!nrst) !full_duplex);
  c_rx_hit: cover property (@(posedge mclk) disable iff (!nrst) rx_pause_hit);
  c_read_status: cover property (@(posedge mclk) disable iff (!nrst)
    last_rd_any && mpd_sel(avs_address, st.base_ok, st.base, `MPD_OFS_STATUS));
endmodule : mpd_port_regs

//--- verif/mpd_port_regs_tb.sv
// self-checking bench for the port register bank: bus rows, reset, pause frames, duplex, base
// assumes mpd_pkg and mpd_defines.svh compiled first; avalon master driven here at posedge
`timescale 1ns/1ns
module mpd_port_regs_tb
  import mpd_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic [4:0]  ofs;
    logic [31:0] wd;
    logic [3:0]  be;
    logic [31:0] exp;
  } mpd_tb_row_s;

  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  port_index = 3'h2;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  mpd_link_s   link = '{mpd_media_rgmii, mpd_spd_100};
  logic        tx_pause_start = 1'b0;
  logic        tx_pause_end = 1'b0;
  mpd_rx_req_s rx_req = '0;
  mpd_tx_hdr_s tx_hdr;
  logic        tx_busy;
  logic        rx_pause_hit;
  logic        full_duplex;
  int          err_count = 0;
  int          compares = 0;
  logic [31:0] rd;
  logic [47:0] sta;
  mpd_link_s   lk [5] = '{'{mpd_media_rgmii, mpd_spd_10}, '{mpd_media_rgmii, mpd_spd_100},
                          '{mpd_media_rgmii, mpd_spd_1000}, '{mpd_media_gmii, mpd_spd_1000},
                          '{mpd_media_fiber, mpd_spd_1000}};
  logic        lk_fdx [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [31:0] rst_val [4] = '{32'h0, 32'h0, 32'h1, 32'h8808};
  logic [2:0]  bases [3] = '{3'h0, 3'h5, 3'h6};
  mpd_tb_row_s rows [12] = '{
    '{1'b1, 5'h00, 32'h89ab_cdef, 4'hf, 32'h0}, '{1'b0, 5'h00, 32'h0, 4'hf, 32'h89ab_cdef},
    '{1'b1, 5'h01, 32'hffff_1234, 4'hf, 32'h0}, '{1'b0, 5'h01, 32'h0, 4'hf, 32'h0000_1234},
    '{1'b1, 5'h02, 32'hffff_fffe, 4'hf, 32'h0}, '{1'b0, 5'h02, 32'h0, 4'hf, 32'h0000_0000},
    '{1'b1, 5'h03, 32'hdead_beef, 4'hf, 32'h0}, '{1'b0, 5'h03, 32'h0, 4'hf, 32'h0000_beef},
    '{1'b1, 5'h04, 32'hffff_ffff, 4'hf, 32'h0}, '{1'b0, 5'h04, 32'h0, 4'hf, 32'h0000_0000},
    '{1'b1, 5'h00, 32'h0000_00aa, 4'h1, 32'h0}, '{1'b0, 5'h00, 32'h0, 4'hf, 32'h89ab_cdaa}};

  mpd_port_regs #(.ADDR_W(8)) dut (
    .mclk            (mclk),
    .nrst            (nrst),
    .port_index      (port_index),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .link            (link),
    .tx_pause_start  (tx_pause_start),
    .tx_pause_end    (tx_pause_end),
    .rx_req          (rx_req),
    .tx_hdr          (tx_hdr),
    .tx_busy         (tx_busy),
    .rx_pause_hit    (rx_pause_hit),
    .full_duplex     (full_duplex)
  );

  initial begin
    forever #25 mclk = ~mclk;
  end

  task close_out;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // one avalon transfer; waits for waitrequest low, only the watchdog ends a hung wait
  task bus(input logic wr, input logic [4:0] ofs, input logic [31:0] wd, input logic [3:0] be);
    @(posedge mclk);
    avs_address    <= {5'h0, port_index} + {3'h0, ofs};
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task do_reset(input logic [2:0] b);
    @(posedge mclk);
    nrst       <= 1'b0;
    port_index <= b;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({avs_waitrequest, full_duplex, tx_busy, rx_pause_hit}, 4'b1100, "reset outputs");
    chk(tx_hdr, {48'h0, 16'h8808}, "reset header");
    @(posedge mclk);
    nrst <= 1'b1;
  endtask : do_reset

  task tx_pulse(input logic is_end);
    @(posedge mclk);
    tx_pause_start <= ~is_end;
    tx_pause_end   <= is_end;
    @(posedge mclk);
    tx_pause_start <= 1'b0;
    tx_pause_end   <= 1'b0;
    @(negedge mclk);
  endtask : tx_pulse

  task rx_frame(input logic uni, input logic [47:0] dst, input logic exp);
    @(posedge mclk);
    rx_req <= '{1'b1, uni, dst};
    @(posedge mclk);
    rx_req <= '{1'b0, 1'b0, 48'h0};
    @(negedge mclk);
    chk(rx_pause_hit, exp, "rx match");
    @(negedge mclk);
    chk(rx_pause_hit, 1'b0, "rx hit width");
  endtask : rx_frame

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    close_out();
  end

  initial begin
    do_reset(3'h2);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 5'(i), 32'h0, 4'hf);
      chk(rd, rst_val[i], "reset value");
    end
    $display("test reset done");
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].ofs, rows[i].wd, rows[i].be);
      if (!rows[i].wr) chk(rd, rows[i].exp, "row readback");
    end
    $display("test rows done");
    sta = 48'h1234_89ab_cdaa;
    tx_pulse(1'b0);
    chk(tx_hdr, {sta, 16'hbeef}, "tx header");
    chk(tx_busy, 1'b1, "tx busy");
    bus(1'b1, 5'h03, 32'h0000_1111, 4'hf);
    bus(1'b1, 5'h00, 32'h5555_0000, 4'hf);
    chk(tx_hdr, {sta, 16'hbeef}, "header mid frame");
    tx_pulse(1'b1);
    chk(tx_busy, 1'b0, "tx idle");
    tx_pulse(1'b0);
    chk(tx_hdr, {48'h1234_5555_0000, 16'h1111}, "next frame header");
    tx_pulse(1'b1);
    $display("test tx done");
    sta = 48'h1234_5555_0000;
    rx_frame(1'b1, sta, 1'b1);
    bus(1'b0, 5'h1f, 32'h0, 4'hf);
    chk(rd, 32'h0000_0004, "status after hit");
    rx_frame(1'b1, sta ^ 48'h1, 1'b0);
    rx_frame(1'b0, sta, 1'b0);
    $display("test rx done");
    for (int i = 0; i < 5; i++) begin
      if (i == 2) bus(1'b1, 5'h02, 32'h0000_0001, 4'hf);
      @(posedge mclk);
      link <= lk[i];
      repeat (2) @(negedge mclk);
      chk(full_duplex, lk_fdx[i], "duplex by link");
    end
    bus(1'b1, 5'h02, 32'h0000_0001, 4'hf);
    @(posedge mclk);
    link <= '{mpd_media_rgmii, mpd_spd_10};
    repeat (2) @(negedge mclk);
    chk(full_duplex, 1'b1, "duplex full on 10");
    $display("test duplex done");
    foreach (bases[i]) begin
      do_reset(bases[i]);
      bus(1'b0, 5'h03, 32'h0, 4'hf);
      chk(rd, (bases[i] > 3'h5) ? 32'h0 : 32'h8808, "base decode");
    end
    $display("test base done");
    close_out();
  end
endmodule : mpd_port_regs_tb
